// ### core/swpm_monitor.sv
// servo warning latch and protection trip monitor with register port
//
// Chosen here: the register offsets and strobed register access.
`default_nettype none
module swpm_monitor #(
  parameter int SEC_CYCLES = swpm_pkg::SEC_CYCLES,
  parameter int FAN_CYCLES = swpm_pkg::FAN_CYCLES
) (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  // register port
  input  wire swpm_pkg::swpm_bus_t i_bus,
  output logic [31:0]              o_rdata,
  // feedback and estimator inputs
  input  wire swpm_pkg::swpm_fb_t  i_fb,
  // pins from outside the clock domain
  input  wire logic                i_alarm_clear,
  input  wire logic                i_fan_running,
  // warnings, errors and outputs
  output logic [9:0]               o_warn,
  output logic [3:0]               o_err,
  output logic                     o_torque_in_limit_output,
  output logic                     o_stop_req,
  output logic [2:0]               o_stop_seq
);

  // magnitude of a signed word; the most negative value
  // still gives its true size as an unsigned number
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    logic [31:0] r;
    r = v[31] ? 32'(-v) : 32'(v);
    return r;
  endfunction

  // two-flop synchronisers for the pin inputs
  logic [1:0] clr_sync;
  logic [1:0] fan_sync;
  logic       alarm_clear;
  logic       fan_running;

  // both pins come from outside the clock, so two flops each
  // fan sync starts high: leaving reset is not a fan stop
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clr_sync <= 2'h0;
      fan_sync <= 2'h3;
    end else begin
      clr_sync <= {clr_sync[0], i_alarm_clear};
      fan_sync <= {fan_sync[0], i_fan_running};
    end
  end
  assign alarm_clear = clr_sync[1];
  assign fan_running = fan_sync[1];

  // settings registers
  // each field comes out of reset at its default
  logic [swpm_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [31:0]                     overspeed_level_setting;
  logic [31:0]                     deviation_excess_level;
  logic [31:0]                     working_range_setting;
  logic [31:0]                     hybrid_deviation_level;
  logic [7:0]                      enc_comm_limit;
  logic [7:0]                      scl_comm_limit;
  logic [9:0]                      latch_enable;
  logic [15:0]                     first_torque_limit;

  // register writes, one cycle strobe
  // unmapped addresses are dropped; the port never stalls
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl                    <= swpm_pkg::CTRL_RST;
      overspeed_level_setting <= swpm_pkg::OVERSPEED_RST;
      deviation_excess_level  <= swpm_pkg::DEV_LEVEL_RST;
      working_range_setting   <= swpm_pkg::RANGE_RST;
      hybrid_deviation_level  <= swpm_pkg::HYB_LEVEL_RST;
      enc_comm_limit          <= swpm_pkg::COMM_LIM_RST;
      scl_comm_limit          <= swpm_pkg::COMM_LIM_RST;
      latch_enable            <= swpm_pkg::LATCH_EN_RST;
      first_torque_limit      <= swpm_pkg::TRQ_LIM_RST;
    end else if (i_bus.we) begin
      unique case (i_bus.addr)
        swpm_pkg::REG_CTRL:      ctrl <= i_bus.wdata[swpm_pkg::CTRL_WIDTH-1:0];
        swpm_pkg::REG_OVERSPEED: overspeed_level_setting <= i_bus.wdata;
        swpm_pkg::REG_DEV_LEVEL: deviation_excess_level <= i_bus.wdata;
        swpm_pkg::REG_RANGE:     working_range_setting <= i_bus.wdata;
        swpm_pkg::REG_HYB_LEVEL: hybrid_deviation_level <= i_bus.wdata;
        swpm_pkg::REG_ENC_LIM:   enc_comm_limit <= i_bus.wdata[7:0];
        swpm_pkg::REG_SCL_LIM:   scl_comm_limit <= i_bus.wdata[7:0];
        swpm_pkg::REG_LATCH_EN:  latch_enable <= i_bus.wdata[9:0];
        swpm_pkg::REG_TRQ_LIM:   first_torque_limit <= i_bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // decoded control fields
  // modes 0 and 3 both close the position loop
  logic [3:0]          latch_time;
  swpm_pkg::swpm_mode_t mode;
  logic                deviation_unit_select;
  logic                eco_fan;
  logic                pos_like;

  assign latch_time            = ctrl[swpm_pkg::CTRL_LATCH_LSB +: 4];
  assign mode                  = swpm_pkg::swpm_mode_t'(ctrl[swpm_pkg::CTRL_MODE_LSB +: 2]);
  assign deviation_unit_select = ctrl[swpm_pkg::CTRL_UNIT_BIT];
  assign eco_fan               = ctrl[swpm_pkg::CTRL_ECO_BIT];
  assign pos_like              = (mode == swpm_pkg::SWPM_POS) || (mode == swpm_pkg::SWPM_FULL);

  // one second tick shared by all hold timers
  // one counter keeps area small, but the first
  // second of a hold may run short by up to one tick
  logic [31:0] sec_cnt;
  logic        sec_tick;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sec_cnt <= 32'h0;
    end else if (sec_tick) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end
  assign sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));

  // fan stop timer; an eco stop while servo off does not count
  // the count parks at the limit so a long stop never wraps
  logic [31:0] fan_cnt;
  logic        fan_stopped;

  assign fan_stopped = !fan_running && !(eco_fan && !i_fb.servo_on);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fan_cnt <= 32'h0;
    end else if (!fan_stopped) begin
      fan_cnt <= 32'h0;
    end else if (fan_cnt != 32'(FAN_CYCLES)) begin
      fan_cnt <= fan_cnt + 32'h1;
    end
  end

  // consecutive communication failure counters, saturating
  // an ok pulse ends the run even when a fail comes beside it
  logic [7:0] enc_fail_cnt;
  logic [7:0] scl_fail_cnt;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enc_fail_cnt <= 8'h0;
    end else if (i_fb.enc_ok) begin
      enc_fail_cnt <= 8'h0;
    end else if (i_fb.enc_fail && enc_fail_cnt != 8'hff) begin
      enc_fail_cnt <= enc_fail_cnt + 8'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_fail_cnt <= 8'h0;
    end else if (i_fb.scl_ok) begin
      scl_fail_cnt <= 8'h0;
    end else if (i_fb.scl_fail && scl_fail_cnt != 8'hff) begin
      scl_fail_cnt <= scl_fail_cnt + 8'h1;
    end
  end

  // warning causes, present state of each condition
  // causes stay combinational and are registered once below
  logic [9:0] cause;

  always_comb begin
    cause = 10'h0;
    cause[swpm_pkg::W_OVERLD] = (i_fb.load_pct >= swpm_pkg::WARN_PCT);
    cause[swpm_pkg::W_REGEN]  = (i_fb.regen_pct >= swpm_pkg::WARN_PCT);
    cause[swpm_pkg::W_BATT]   = (i_fb.batt_mv <= swpm_pkg::BATT_WARN_MV);
    cause[swpm_pkg::W_FAN]    = (fan_cnt == 32'(FAN_CYCLES));
    cause[swpm_pkg::W_ENCCOM] = (enc_fail_cnt > enc_comm_limit);
    cause[swpm_pkg::W_ENCHOT] = i_fb.enc_hot;
    cause[swpm_pkg::W_OSC]    = i_fb.osc_det;
    cause[swpm_pkg::W_LIFE]   = i_fb.life_short;
    cause[swpm_pkg::W_SCLALM] = i_fb.scl_alarm;
    cause[swpm_pkg::W_SCLCOM] = (scl_fail_cnt > scl_comm_limit);
  end

  // hold time: 0 or above ten seconds means no limit
  // battery and lifetime warnings never time out at all
  logic       hold_forever;
  logic [9:0] fixed_forever;

  assign hold_forever  = (latch_time == 4'h0) || (latch_time > swpm_pkg::LATCH_MAX_S);
  assign fixed_forever = (10'h1 << swpm_pkg::W_BATT) | (10'h1 << swpm_pkg::W_LIFE);

  // per-warning latch with its own timer; a live cause beats a clear
  // the timer reloads while the cause stands and counts
  // down on ticks only once it has gone
  logic [3:0] hold_cnt [10];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_warn <= 10'h0;
      for (int i = 0; i < swpm_pkg::NUM_WARN; i++) begin
        hold_cnt[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < swpm_pkg::NUM_WARN; i++) begin
        if (cause[i]) begin
          o_warn[i]   <= 1'b1;
          hold_cnt[i] <= latch_time;
        end else if (alarm_clear) begin
          o_warn[i] <= 1'b0;
        end else if (o_warn[i]) begin
          if (fixed_forever[i]) begin
            // battery and lifetime never time out
            o_warn[i] <= 1'b1;
          end else if (!latch_enable[i]) begin
            o_warn[i] <= 1'b0;
          end else if (!hold_forever && sec_tick) begin
            if (hold_cnt[i] <= 4'h1) begin
              o_warn[i] <= 1'b0;
            end
            hold_cnt[i] <= hold_cnt[i] - 4'h1;
          end
        end
      end
    end
  end

  // protection trip conditions
  // 24.0 and 34.0 only in position-like modes, over-speed in all
  logic [31:0] dev_sel;
  logic [31:0] hyb_diff;
  logic [3:0]  trip;

  // encoder deviation is taken after the command filters, so they cannot act
  assign dev_sel  = deviation_unit_select ? abs32(i_fb.dev_enc) : abs32(i_fb.dev_cmd);
  assign hyb_diff = abs32(32'(i_fb.pos_enc - i_fb.pos_scl));

  always_comb begin
    trip = 4'h0;
    trip[swpm_pkg::E_DEV]   = pos_like && (dev_sel > deviation_excess_level);
    trip[swpm_pkg::E_HYB]   = (mode == swpm_pkg::SWPM_FULL) &&
                              (hyb_diff > hybrid_deviation_level);
    trip[swpm_pkg::E_OVSPD] = (abs32(i_fb.speed_rpm) > overspeed_level_setting);
    // working range, only with servo on
    trip[swpm_pkg::E_SWLIM] = pos_like && i_fb.servo_on &&
                              (abs32(i_fb.rev_beyond) > working_range_setting);
  end

  // errors are sticky until alarm clear; a trip in the clear cycle stays
  // a clear held down keeps wiping errors whose trip has gone
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_err <= 4'h0;
    end else begin
      o_err <= trip | (alarm_clear ? 4'h0 : o_err);
    end
  end

  // stop request follows any error, using the configured sequence
  // built from the next error value so it moves with o_err
  // the braking itself belongs to the drive stage
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stop_req <= 1'b0;
      o_stop_seq <= 3'h0;
    end else begin
      o_stop_req <= |(trip | (alarm_clear ? 4'h0 : o_err));
      o_stop_seq <= ctrl[swpm_pkg::CTRL_STOP_LSB +: 3];
    end
  end

  // torque clamp flag; compared in magnitude so both directions count
  // a command equal to the limit already counts as clamped
  logic [15:0] trq_mag;

  assign trq_mag = i_fb.torque_cmd[15] ? 16'(-i_fb.torque_cmd) : 16'(i_fb.torque_cmd);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_torque_in_limit_output <= 1'b0;
    end else begin
      o_torque_in_limit_output <= (trq_mag >= first_torque_limit);
    end
  end

  // read data, registered, one cycle after the strobe only
  // status is taken at the strobe edge, not at the data edge
  // unmapped reads give zero so software never sees stale data
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (i_bus.re) begin
      unique case (i_bus.addr)
        swpm_pkg::REG_CTRL:      next_rdata = 32'(ctrl);
        swpm_pkg::REG_OVERSPEED: next_rdata = overspeed_level_setting;
        swpm_pkg::REG_DEV_LEVEL: next_rdata = deviation_excess_level;
        swpm_pkg::REG_RANGE:     next_rdata = working_range_setting;
        swpm_pkg::REG_HYB_LEVEL: next_rdata = hybrid_deviation_level;
        swpm_pkg::REG_ENC_LIM:   next_rdata = 32'(enc_comm_limit);
        swpm_pkg::REG_SCL_LIM:   next_rdata = 32'(scl_comm_limit);
        swpm_pkg::REG_LATCH_EN:  next_rdata = 32'(latch_enable);
        swpm_pkg::REG_STATUS: begin
          next_rdata[9:0] = o_warn;
          next_rdata[swpm_pkg::STAT_ERR_LSB +: 4] = o_err;
          next_rdata[swpm_pkg::STAT_TLC_BIT] = o_torque_in_limit_output;
        end
        swpm_pkg::REG_TRQ_LIM:   next_rdata = 32'(first_torque_limit);
        default:                 next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ### core/swpm_pkg.sv
// constants, types and register map of the servo warning and protection monitor
`default_nettype none
package swpm_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OVERSPEED = 8'h04;
  localparam logic [7:0] REG_DEV_LEVEL = 8'h08;
  localparam logic [7:0] REG_RANGE     = 8'h0c;
  localparam logic [7:0] REG_HYB_LEVEL = 8'h10;
  localparam logic [7:0] REG_ENC_LIM   = 8'h14;
  localparam logic [7:0] REG_SCL_LIM   = 8'h18;
  localparam logic [7:0] REG_LATCH_EN  = 8'h1c;
  localparam logic [7:0] REG_STATUS    = 8'h20;
  localparam logic [7:0] REG_TRQ_LIM   = 8'h24;

  // control register field positions
  localparam int CTRL_LATCH_LSB = 0;   // [3:0] warning latch time, 0 = unlimited
  localparam int CTRL_MODE_LSB  = 4;   // [5:4] control mode
  localparam int CTRL_UNIT_BIT  = 8;   // deviation unit select
  localparam int CTRL_STOP_LSB  = 9;   // [11:9] alarm stop sequence
  localparam int CTRL_ECO_BIT   = 12;  // upper fan stops at servo off
  localparam int CTRL_WIDTH     = 13;

  // status register field positions
  localparam int STAT_ERR_LSB = 16;  // [19:16] errors 24.0, 25.0, 26.0, 34.0
  localparam int STAT_TLC_BIT = 24;

  // warning indices (codes a0..a9)
  localparam int NUM_WARN  = 10;
  localparam int W_OVERLD  = 0;
  localparam int W_REGEN   = 1;
  localparam int W_BATT    = 2;
  localparam int W_FAN     = 3;
  localparam int W_ENCCOM  = 4;
  localparam int W_ENCHOT  = 5;
  localparam int W_OSC     = 6;
  localparam int W_LIFE    = 7;
  localparam int W_SCLALM  = 8;
  localparam int W_SCLCOM  = 9;

  // error indices
  localparam int E_DEV   = 0;  // 24.0
  localparam int E_HYB   = 1;  // 25.0
  localparam int E_OVSPD = 2;  // 26.0
  localparam int E_SWLIM = 3;  // 34.0

  // thresholds and reset values
  localparam logic [7:0]  WARN_PCT       = 8'h55;       // 85 percent
  localparam logic [15:0] BATT_WARN_MV   = 16'h0c80;    // 3200 mV
  localparam logic [3:0]  LATCH_MAX_S    = 4'ha;        // 10 s
  localparam logic [31:0] MOTOR_MAX_RPM  = 32'h00001770; // plain default, 6000 r/min
  localparam logic [31:0] OVERSPEED_RST  = (MOTOR_MAX_RPM * 32'd12) / 32'd10;
  localparam logic [31:0] DEV_LEVEL_RST  = 32'h000186a0; // 100000 pulses
  localparam logic [31:0] HYB_LEVEL_RST  = 32'h00003e80; // 16000 pulses
  localparam logic [31:0] RANGE_RST      = 32'h0000000a; // plain default, 10 rev
  localparam logic [7:0]  COMM_LIM_RST   = 8'h08;
  localparam logic [15:0] TRQ_LIM_RST    = 16'h7fff;
  localparam logic [9:0]  LATCH_EN_RST   = 10'h3ff;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 13'h0001;

  // timing: one second of hold time, one second of stopped fan
  localparam int CLK_HZ       = 100_000_000;
  localparam int HOLD_TICK_S  = 1;
  localparam int FAN_STOP_S   = 1;
  localparam int SEC_CYCLES   = CLK_HZ * HOLD_TICK_S;
  localparam int FAN_CYCLES   = CLK_HZ * FAN_STOP_S;

  // control modes
  typedef enum logic [1:0] {
    SWPM_POS  = 2'b00,
    SWPM_VEL  = 2'b01,
    SWPM_TRQ  = 2'b10,
    SWPM_FULL = 2'b11
  } swpm_mode_t;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } swpm_bus_t;

  // feedback from estimators, encoder and scale, all on the drive clock
  typedef struct packed {
    logic [7:0]         load_pct;
    logic [7:0]         regen_pct;
    logic [15:0]        batt_mv;
    logic               enc_fail;
    logic               enc_ok;
    logic               enc_hot;
    logic               osc_det;
    logic               life_short;
    logic               scl_alarm;
    logic               scl_fail;
    logic               scl_ok;
    logic               servo_on;
    logic signed [31:0] speed_rpm;
    logic signed [31:0] dev_cmd;
    logic signed [31:0] dev_enc;
    logic signed [31:0] rev_beyond;
    logic signed [31:0] pos_enc;
    logic signed [31:0] pos_scl;
    logic signed [15:0] torque_cmd;
  } swpm_fb_t;
endpackage
`default_nettype wire

// ### bench/swpm_link_model.sv
// encoder and scale transaction source for the monitor bench
`default_nettype none
module swpm_link_model (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  // burst request
  input  wire logic       i_go,
  input  wire logic [7:0] i_fails,
  // transaction results
  output logic            o_fail,
  output logic            o_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [3:0] idle;

  // failed transactions back to back, then one good one
  // the good one comes late so the bench can look at the flag first
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      left   <= 8'h00;
      idle   <= 4'h0;
      o_fail <= 1'b0;
      o_ok   <= 1'b0;
    end else if (i_go) begin
      left <= i_fails;
      idle <= 4'h8;
    end else if (left != 8'h00) begin
      o_fail <= 1'b1;
      left   <= left - 8'h01;
    end else begin
      o_fail <= 1'b0;
      o_ok   <= (idle == 4'h1);
      if (idle != 4'h0) begin
        idle <= idle - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/swpm_monitor_assertions.sv
// port assertions of the warning and protection monitor
`default_nettype none
module swpm_monitor_assertions #(
  parameter int SEC_CYCLES = 20,
  parameter int FAN_CYCLES = 20
) (
  // clock, reset and inputs
  input wire logic                i_ref_clk,
  input wire logic                i_rst_b,
  input wire swpm_pkg::swpm_bus_t i_bus,
  input wire swpm_pkg::swpm_fb_t  i_fb,
  input wire logic                i_alarm_clear,
  input wire logic                i_fan_running,
  // outputs watched
  input wire logic [31:0]         o_rdata,
  input wire logic [9:0]          o_warn,
  input wire logic [3:0]          o_err,
  input wire logic                o_torque_in_limit_output,
  input wire logic                o_stop_req,
  input wire logic [2:0]          o_stop_seq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  chk_load_warn: assert property (i_fb.load_pct >= swpm_pkg::WARN_PCT
    |=> o_warn[swpm_pkg::W_OVERLD]) else $error("load warning missing");
  chk_regen_warn: assert property (i_fb.regen_pct >= swpm_pkg::WARN_PCT
    |=> o_warn[swpm_pkg::W_REGEN]) else $error("regen warning missing");
  chk_batt_warn: assert property (i_fb.batt_mv <= swpm_pkg::BATT_WARN_MV
    |=> o_warn[swpm_pkg::W_BATT]) else $error("battery warning missing");
  chk_hot_warn: assert property (i_fb.enc_hot
    |=> o_warn[swpm_pkg::W_ENCHOT]) else $error("overheat warning missing");
  chk_scale_alarm: assert property (i_fb.scl_alarm
    |=> o_warn[swpm_pkg::W_SCLALM]) else $error("scale warning missing");
  chk_speed_trip: assert property (i_fb.speed_rpm > signed'(swpm_pkg::OVERSPEED_RST)
    |=> o_err[swpm_pkg::E_OVSPD]) else $error("over-speed not tripped");
  chk_clear_drops: assert property ((i_alarm_clear && !i_fb.enc_hot) [*3]
    |=> !o_warn[swpm_pkg::W_ENCHOT]) else $error("clear did not drop warning");
  chk_err_sticky: assert property (!i_alarm_clear && !$past(i_alarm_clear)
    && !$past(i_alarm_clear, 2) |=> (o_err & $past(o_err)) == $past(o_err))
    else $error("error bit dropped without clear");
  chk_stop_req: assert property (o_stop_req == (o_err != 4'h0))
    else $error("stop request not tied to errors");
  chk_stop_seq: assert property (!$past(i_bus.we) && !$past(i_bus.we, 2)
    |-> $stable(o_stop_seq)) else $error("stop sequence moved without write");
  chk_rdata_idle: assert property (!$past(i_bus.re) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  // main scenarios reached
  cover property (o_err[swpm_pkg::E_SWLIM]);
  cover property (o_warn[swpm_pkg::W_FAN]);
  cover property (o_torque_in_limit_output);
  cover property ($fell(o_warn[swpm_pkg::W_ENCHOT]) && !i_alarm_clear);
endmodule

bind swpm_monitor swpm_monitor_assertions #(
  .SEC_CYCLES(SEC_CYCLES),
  .FAN_CYCLES(FAN_CYCLES)
) i_swpm_monitor_assertions (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .i_fb(i_fb),
  .i_alarm_clear(i_alarm_clear), .i_fan_running(i_fan_running), .o_rdata(o_rdata),
  .o_warn(o_warn), .o_err(o_err), .o_torque_in_limit_output(o_torque_in_limit_output),
  .o_stop_req(o_stop_req), .o_stop_seq(o_stop_seq)
);
`default_nettype wire

// ### bench/tb.sv
// self-checking bench of the warning and protection monitor
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  op;
    logic [31:0] val;
    logic [9:0]  w;
    logic [3:0]  e;
    logic        t;
  } swpm_row_t;
  logic                i_ref_clk;
  logic                i_rst_b;
  swpm_pkg::swpm_bus_t bus;
  swpm_pkg::swpm_fb_t  fbd;
  swpm_pkg::swpm_fb_t  fb;
  swpm_pkg::swpm_fb_t  base;
  logic                clr;
  logic                fan;
  logic                go;
  logic [7:0]          fails;
  logic                lfail;
  logic                lok;
  logic [31:0]         rdata;
  logic [9:0]          warn;
  logic [3:0]          err;
  logic                torque_in_limit_output;
  logic                sreq;
  logic [2:0]          sseq;
  int                  error_cnt;
  int                  check_count;
  swpm_row_t           rows[17];

  // one link model feeds both transaction channels
  always_comb begin
    fb = fbd;
    fb.enc_fail = lfail;
    fb.enc_ok = lok;
    fb.scl_fail = lfail;
    fb.scl_ok = lok;
  end
  always #5 i_ref_clk = ~i_ref_clk;

  swpm_monitor #(.SEC_CYCLES(20), .FAN_CYCLES(20)) i_swpm_monitor (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata), .i_fb(fb),
    .i_alarm_clear(clr), .i_fan_running(fan), .o_warn(warn), .o_err(err),
    .o_torque_in_limit_output(torque_in_limit_output), .o_stop_req(sreq), .o_stop_seq(sseq));
  swpm_link_model i_swpm_link_model (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_go(go), .i_fails(fails),
    .o_fail(lfail), .o_ok(lok));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_ref_clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_ref_clk);
    bus.re <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // one input field changed, the rest left as they were
  task automatic put(input logic [3:0] op, input logic [31:0] v);
    @(posedge i_ref_clk);
    case (op)
      4'h0: fbd.load_pct <= v[7:0];
      4'h1: fbd.regen_pct <= v[7:0];
      4'h2: fbd.batt_mv <= v[15:0];
      4'h3: fbd.enc_hot <= v[0];
      4'h4: fbd.osc_det <= v[0];
      4'h5: fbd.life_short <= v[0];
      4'h6: fbd.scl_alarm <= v[0];
      4'h7: fbd.speed_rpm <= v;
      4'h8: fbd.dev_cmd <= v;
      4'h9: fbd.rev_beyond <= v;
      4'ha: fbd.torque_cmd <= v[15:0];
      4'hb: fbd.dev_enc <= v;
      default: fbd.pos_enc <= v;
    endcase
  endtask
  task automatic rest;
    @(posedge i_ref_clk);
    fbd <= base;
  endtask
  task automatic clear;
    @(posedge i_ref_clk);
    clr <= 1'b1;
    tick(4);
    clr <= 1'b0;
    tick(3);
  endtask
  task automatic burst(input logic [7:0] n);
    @(posedge i_ref_clk);
    go <= 1'b1;
    fails <= n;
    @(posedge i_ref_clk);
    go <= 1'b0;
    tick(int'(n) + 4);
  endtask
  task automatic wait_warn(input int b, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && warn[b] !== v; n++) tick(1);
    check(32'(warn[b]), 32'(v));
    if (n == lim) summarize();
  endtask

  // a hang ends the run as a failure
  initial begin
    #500us;
    error_cnt++;
    summarize();
  end

  initial begin
    rows = '{'{4'h0, 32'd84, 10'h000, 4'h0, 1'b0}, '{4'h0, 32'd85, 10'h001, 4'h0, 1'b0},
             '{4'h1, 32'd85, 10'h002, 4'h0, 1'b0}, '{4'h2, 32'd3200, 10'h004, 4'h0, 1'b0},
             '{4'h2, 32'd3201, 10'h000, 4'h0, 1'b0}, '{4'h3, 32'd1, 10'h020, 4'h0, 1'b0},
             '{4'h4, 32'd1, 10'h040, 4'h0, 1'b0}, '{4'h5, 32'd1, 10'h080, 4'h0, 1'b0},
             '{4'h6, 32'd1, 10'h100, 4'h0, 1'b0}, '{4'h7, 32'd7200, 10'h000, 4'h0, 1'b0},
             '{4'h7, 32'd7201, 10'h000, 4'h4, 1'b0}, '{4'h8, 32'd100000, 10'h000, 4'h0, 1'b0},
             '{4'h8, 32'd100001, 10'h000, 4'h1, 1'b0}, '{4'h9, 32'd10, 10'h000, 4'h0, 1'b0},
             '{4'h9, 32'd11, 10'h000, 4'h8, 1'b0}, '{4'ha, 32'hffffff9c, 10'h000, 4'h0, 1'b1},
             '{4'ha, 32'd99, 10'h000, 4'h0, 1'b0}};
    i_ref_clk = 1'b0;
    i_rst_b = 1'b0;
    bus = '0;
    fbd = '0;
    fbd.batt_mv = 16'h1000;
    fbd.servo_on = 1'b1;
    base = fbd;
    clr = 1'b0;
    fan = 1'b1;
    go = 1'b0;
    fails = 8'h00;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd(swpm_pkg::REG_DEV_LEVEL, 32'd100000);
    rd(swpm_pkg::REG_OVERSPEED, 32'd7200);
    rd(swpm_pkg::REG_HYB_LEVEL, 32'd16000);
    rd(8'h3c, 32'h0);
    // stop sequence 5, latch off, torque limit 100
    wr(swpm_pkg::REG_CTRL, 32'h0000_0a01);
    wr(swpm_pkg::REG_LATCH_EN, 32'h0);
    wr(swpm_pkg::REG_TRQ_LIM, 32'd100);
    tick(1);
    check(32'(sseq), 32'h5);
    foreach (rows[i]) begin
      put(rows[i].op, rows[i].val);
      tick(1);
      check(32'(warn), 32'(rows[i].w));
      check(32'(err), 32'(rows[i].e));
      check(32'(torque_in_limit_output), 32'(rows[i].t));
      rest();
      tick(1);
      check(32'(warn), 32'(rows[i].w & 10'h084));
      check(32'(err), 32'(rows[i].e));
      clear();
      $display("row %0d done", i);
    end
    // two second hold, two warnings at different times
    wr(swpm_pkg::REG_LATCH_EN, 32'h3ff);
    wr(swpm_pkg::REG_CTRL, 32'h0000_0a02);
    put(4'h3, 32'd1);
    rest();
    tick(16);
    check(32'(warn[5]), 32'h1);
    put(4'h4, 32'd1);
    rest();
    tick(26);
    check(32'(warn[6:5]), 32'h2);
    wait_warn(6, 1'b0, 60);
    put(4'h3, 32'd1);
    rest();
    clear();
    check(32'(warn), 32'h0);
    $display("latch test done");
    // fan stop: not before one second, then raised
    fan <= 1'b0;
    tick(15);
    check(32'(warn[3]), 32'h0);
    wait_warn(3, 1'b1, 40);
    rd(swpm_pkg::REG_STATUS, 32'h0000_0008);
    fan <= 1'b1;
    clear();
    // eco variant with servo off, unlimited hold
    wr(swpm_pkg::REG_CTRL, 32'h0000_1a00);
    fbd.servo_on <= 1'b0;
    fan <= 1'b0;
    tick(40);
    check(32'(warn[3]), 32'h0);
    fan <= 1'b1;
    rest();
    put(4'h3, 32'd1);
    rest();
    tick(60);
    check(32'(warn[5]), 32'h1);
    clear();
    $display("fan test done");
    burst(8'd8);
    check(32'({warn[9], warn[4]}), 32'h0);
    tick(8);
    burst(8'd9);
    check(32'({warn[9], warn[4]}), 32'h3);
    clear();
    $display("link test done");
    // encoder unit deviation, then velocity mode
    wr(swpm_pkg::REG_CTRL, 32'h0000_0100);
    put(4'h8, 32'd200000);
    tick(1);
    check(32'(err), 32'h0);
    put(4'hb, 32'd100001);
    tick(1);
    check(32'(err), 32'h1);
    rest();
    clear();
    wr(swpm_pkg::REG_CTRL, 32'h0000_0010);
    put(4'h8, 32'd100001);
    put(4'h9, 32'd11);
    tick(1);
    check(32'(err), 32'h0);
    rest();
    // full-closed hybrid deviation
    wr(swpm_pkg::REG_CTRL, 32'h0000_0030);
    put(4'hc, 32'd16000);
    tick(1);
    check(32'(err), 32'h0);
    put(4'hc, 32'd16001);
    tick(1);
    check(32'(err), 32'h2);
    check(32'(sreq), 32'h1);
    rest();
    clear();
    $display("protection test done");
    summarize();
  end
endmodule
`default_nettype wire
